//--- timer_capture_compare_unit.v
// Purpose: Two chainable 16-bit timers with one capture and one compare channel
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Pins are synchronised; prescale and capture counts run on CLK
//
// Operation
// - Gate enable accumulates while gate pin high; ignored with external clock.
// - Clock-source bit picks external pin rising edges or internal clock.
// - Capture latches the 16-bit count of the selected time base.
// - Simple modes capture on every falling or every rising edge.
// - Edge mode captures on every rising and falling edge.
// - Prescaled modes capture on every fourth or sixteenth rising edge.
// - Capture time base is the first or second timer, as selected.
// - A capture pin event raises a wake request in Sleep or Idle.
// - Captured values queue in a four-entry FIFO read in arrival order.
// - Capture interrupt once one to four FIFO entries are filled.
// - Compare time base is the first or second timer, as selected; PWM needs the first timer, unchained.
// - Compare uses one or two compare registers depending on mode.
// - A match changes the pin, giving one pulse or a repeating sequence.
// - Each compare match raises a compare interrupt request.
// - Modes: one-shot low/high, toggle, delayed, continuous, PWM, PWM with fault.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "tccu_map.vh"

module timer_capture_compare_unit #(
  parameter FIFO_DEPTH = 4
) (
  input  wire        CLK,
  input  wire        RESET,
  input  wire [3:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  input  wire        EXT_CLK_PIN,
  input  wire        GATE_PIN,
  input  wire        CAPTURE_PIN,
  input  wire        FAULT_PIN,
  input  wire        IDLE_MODE,
  input  wire        SLEEP_MODE,
  output reg         COMPARE_PIN,
  output wire        CAPTURE_IRQ,
  output wire        COMPARE_IRQ,
  output wire        WAKE_REQ
);

  // Pin synchronisers: stage a feeds only stage b
  reg [3:0] sync_a_q;
  reg [3:0] sync_b_q;
  reg [3:0] sync_c_q;
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync_a_q <= 4'h0;
      sync_b_q <= 4'h0;
      sync_c_q <= 4'h0;
    end else begin
      sync_a_q <= {FAULT_PIN, CAPTURE_PIN, GATE_PIN, EXT_CLK_PIN};
      sync_b_q <= sync_a_q;
      sync_c_q <= sync_b_q;
    end
  end
  wire ext_rise = sync_b_q[0] & ~sync_c_q[0];
  wire gate_lvl = sync_b_q[1];
  // Edge detectors compare the last two synchroniser stages
  wire cap_rise = sync_b_q[2] & ~sync_c_q[2];
  wire cap_fall = ~sync_b_q[2] & sync_c_q[2];
  wire fault    = sync_b_q[3];

  reg  [15:0] tpc_q;
  reg  [15:0] tmr1_q;
  reg  [15:0] tmr2_q;
  reg  [15:0] per1_q;
  reg  [15:0] per2_q;
  reg  [7:0]  cap_ctrl_q;
  reg  [3:0]  cmp_ctrl_q;
  reg  [15:0] cmp_pri_q;
  reg  [15:0] cmp_sec_q;
  reg  [3:0]  evt_q;
  reg  [7:0]  ps_cnt_q;
  reg  [3:0]  edge_cnt_q;
  reg         fault_lock_q;
  reg         oneshot_done_q;

  wire wr_tpc  = WR && ADDR == `OFF_TPC;
  wire chain   = tpc_q[`TPC_CHAIN];
  wire ext_sel = tpc_q[`TPC_CLKSRC];

  // Prescale terminal count
  function [7:0] ps_last;
    input [1:0] code;
    begin
      case (code)
        2'b00:   ps_last = 8'h00;
        2'b01:   ps_last = 8'h07;
        2'b10:   ps_last = 8'h3f;
        default: ps_last = 8'hff;
      endcase
    end
  endfunction

  wire halted  = IDLE_MODE & tpc_q[`TPC_IDLE_STOP];
  wire src_evt = ext_sel ? ext_rise : 1'b1;
  wire gate_ok = ext_sel | ~tpc_q[`TPC_GATE] | gate_lvl;
  wire in_evt  = tpc_q[`TPC_RUN] & ~halted & src_evt & gate_ok;
  wire ps_tick = in_evt && ps_cnt_q == ps_last(tpc_q[`TPC_PS_HI:`TPC_PS_LO]);

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ps_cnt_q <= 8'h00;
    end else if (wr_tpc || ps_tick) begin
      ps_cnt_q <= 8'h00;
    end else if (in_evt) begin
      ps_cnt_q <= ps_cnt_q + 8'h01;
    end
  end

  // Timers: period match rolls to zero; chained pair uses both period words
  wire [31:0] cnt32   = {tmr2_q, tmr1_q};
  wire [31:0] per32   = {per2_q, per1_q};
  wire        wrap32  = chain && cnt32 == per32;
  wire        wrap1   = ~chain && tmr1_q == per1_q;
  // Second timer only moves as the upper half of a chained pair
  wire        tick1   = ps_tick;
  wire        tmr_ovf = ps_tick & (chain ? wrap32 : wrap1);

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tmr1_q <= 16'h0000;
      tmr2_q <= 16'h0000;
    end else if (WR && ADDR == `OFF_TMR1) begin
      tmr1_q <= WDATA;
    end else if (WR && ADDR == `OFF_TMR2) begin
      tmr2_q <= WDATA;
    end else if (tick1 && chain) begin
      if (wrap32) begin
        tmr1_q <= 16'h0000;
        tmr2_q <= 16'h0000;
      end else begin
        {tmr2_q, tmr1_q} <= cnt32 + 32'h0000_0001;
      end
    end else if (tick1) begin
      tmr1_q <= wrap1 ? 16'h0000 : tmr1_q + 16'h0001;
    end
  end

  // Capture channel
  wire [2:0]  cap_mode = cap_ctrl_q[`CAP_MODE_HI:`CAP_MODE_LO];
  wire [15:0] cap_base = cap_ctrl_q[`CAP_TSEL] ? tmr2_q : tmr1_q;
  reg         cap_evt;
  always @* begin
    case (cap_mode)
      `CAPM_EDGE:   cap_evt = cap_rise | cap_fall;
      `CAPM_FALL:   cap_evt = cap_fall;
      `CAPM_RISE:   cap_evt = cap_rise;
      `CAPM_RISE4:  cap_evt = cap_rise && edge_cnt_q[1:0] == 2'h3;
      `CAPM_RISE16: cap_evt = cap_rise && edge_cnt_q == 4'hf;
      default:      cap_evt = 1'b0;
    endcase
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      edge_cnt_q <= 4'h0;
    end else if (WR && ADDR == `OFF_CAP_CTRL) begin
      edge_cnt_q <= 4'h0;
    end else if (cap_rise) begin
      edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end

  reg  [15:0] fifo_mem [0:FIFO_DEPTH-1];
  reg  [1:0]  rd_ptr_q;
  reg  [1:0]  wr_ptr_q;
  reg  [2:0]  fill_q;
  wire        fifo_full = fill_q == FIFO_DEPTH;
  wire        fifo_pop  = RD && ADDR == `OFF_CAP_DATA && fill_q != 3'h0;
  wire        fifo_push = cap_evt & ~fifo_full;
  reg         overflow_q;

  always @(posedge CLK) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr_q] <= cap_base;
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rd_ptr_q   <= 2'h0;
      wr_ptr_q   <= 2'h0;
      fill_q     <= 3'h0;
      overflow_q <= 1'b0;
    end else begin
      if (fifo_push) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      if (fifo_pop) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end
      fill_q <= fill_q + {2'h0, fifo_push} - {2'h0, fifo_pop};
      if (cap_evt && fifo_full) begin
        overflow_q <= 1'b1;
      end else if (WR && ADDR == `OFF_CAP_STAT && WDATA[3]) begin
        overflow_q <= 1'b0;
      end
    end
  end

  wire [2:0] cap_thr = {1'b0, cap_ctrl_q[`CAP_THR_HI:`CAP_THR_LO]} + 3'h1;
  wire       cap_hit = fifo_push && (fill_q + 3'h1) == cap_thr;

  // Compare channel
  wire [2:0]  cmp_mode = cmp_ctrl_q[`CMP_MODE_HI:`CMP_MODE_LO];
  wire [15:0] cmp_base = cmp_ctrl_q[`CMP_TSEL] ? tmr2_q : tmr1_q;
  wire        pri_hit  = cmp_mode != `CMPM_OFF && cmp_base == cmp_pri_q;
  wire        two_reg  = cmp_mode == `CMPM_DELAYED || cmp_mode == `CMPM_CONT;
  wire        sec_hit  = two_reg && cmp_base == cmp_sec_q;
  wire        pwm_mode = cmp_mode == `CMPM_PWM || cmp_mode == `CMPM_PWM_FAULT;
  wire        pwm_wrap = cmp_ctrl_q[`CMP_TSEL] ? 1'b0 : wrap1 & ps_tick;
  wire        cmp_hit  = pri_hit | sec_hit;
  wire        wr_cmp   = WR && ADDR == `OFF_CMP_CTRL;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      COMPARE_PIN    <= 1'b0;
      oneshot_done_q <= 1'b0;
      fault_lock_q   <= 1'b0;
    end else if (wr_cmp) begin
      COMPARE_PIN    <= WDATA[`CMP_MODE_HI:`CMP_MODE_LO] == `CMPM_OS_LOW;
      oneshot_done_q <= 1'b0;
      fault_lock_q   <= 1'b0;
    end else begin
      if (cmp_mode == `CMPM_PWM_FAULT && fault) begin
        fault_lock_q <= 1'b1;
      end
      case (cmp_mode)
        `CMPM_OS_HIGH: if (pri_hit && !oneshot_done_q) begin
          COMPARE_PIN    <= 1'b1;
          oneshot_done_q <= 1'b1;
        end
        `CMPM_OS_LOW: if (pri_hit && !oneshot_done_q) begin
          COMPARE_PIN    <= 1'b0;
          oneshot_done_q <= 1'b1;
        end
        `CMPM_TOGGLE: if (pri_hit) begin
          COMPARE_PIN <= ~COMPARE_PIN;
        end
        `CMPM_DELAYED: if (!oneshot_done_q) begin
          if (pri_hit) begin
            COMPARE_PIN <= 1'b1;
          end else if (sec_hit && COMPARE_PIN) begin
            COMPARE_PIN    <= 1'b0;
            oneshot_done_q <= 1'b1;
          end
        end
        `CMPM_CONT: begin
          if (pri_hit) begin
            COMPARE_PIN <= 1'b1;
          end else if (sec_hit) begin
            COMPARE_PIN <= 1'b0;
          end
        end
        `CMPM_PWM, `CMPM_PWM_FAULT: begin
          if (fault_lock_q || (cmp_mode == `CMPM_PWM_FAULT && fault)) begin
            COMPARE_PIN <= 1'b0;
          end else if (pwm_wrap) begin
            COMPARE_PIN <= cmp_pri_q != 16'h0000;
          end else if (pri_hit) begin
            COMPARE_PIN <= 1'b0;
          end
        end
        default: COMPARE_PIN <= 1'b0;
      endcase
    end
  end

  // Sticky events: set wins over write-one-to-clear
  wire [3:0] evt_set = {tmr_ovf, fault_lock_q, cmp_hit & ~pwm_mode | pri_hit & pwm_mode, cap_hit};
  wire [3:0] evt_clr = (WR && ADDR == `OFF_EVT_STAT) ? WDATA[3:0] : 4'h0;
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      evt_q <= 4'h0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end
  assign CAPTURE_IRQ = evt_q[`EVT_CAP];
  assign COMPARE_IRQ = evt_q[`EVT_CMP];
  assign WAKE_REQ    = (SLEEP_MODE | IDLE_MODE) & cap_evt;

  // Register writes
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tpc_q      <= `TPC_RESET;
      per1_q     <= `PER_RESET;
      per2_q     <= `PER_RESET;
      cap_ctrl_q <= 8'h00;
      cmp_ctrl_q <= 4'h0;
      cmp_pri_q  <= 16'h0000;
      cmp_sec_q  <= 16'h0000;
    end else if (WR) begin
      case (ADDR)
        `OFF_TPC:      tpc_q      <= WDATA & `TPC_MASK;
        `OFF_PER1:     per1_q     <= WDATA;
        `OFF_PER2:     per2_q     <= WDATA;
        `OFF_CAP_CTRL: cap_ctrl_q <= WDATA[7:0];
        `OFF_CMP_CTRL: cmp_ctrl_q <= WDATA[3:0];
        `OFF_CMP_PRI:  cmp_pri_q  <= WDATA;
        `OFF_CMP_SEC:  cmp_sec_q  <= WDATA;
        default:       tpc_q      <= tpc_q;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        `OFF_TPC:      RDATA <= tpc_q;
        `OFF_TMR1:     RDATA <= tmr1_q;
        `OFF_TMR2:     RDATA <= tmr2_q;
        `OFF_PER1:     RDATA <= per1_q;
        `OFF_PER2:     RDATA <= per2_q;
        `OFF_CAP_CTRL: RDATA <= {8'h00, cap_ctrl_q};
        `OFF_CAP_DATA: RDATA <= fill_q != 3'h0 ? fifo_mem[rd_ptr_q] : 16'h0000;
        `OFF_CAP_STAT: RDATA <= {12'h000, overflow_q, fill_q};
        `OFF_CMP_CTRL: RDATA <= {12'h000, cmp_ctrl_q};
        `OFF_CMP_PRI:  RDATA <= cmp_pri_q;
        `OFF_CMP_SEC:  RDATA <= cmp_sec_q;
        `OFF_EVT_STAT: RDATA <= {11'h000, COMPARE_PIN, evt_q};
        default:       RDATA <= 16'h0000;
      endcase
    end else begin
      RDATA <= 16'h0000;
    end
  end

endmodule

//--- tccu_map.vh
// Purpose: Register offsets, field positions and reset values of the timer/capture/compare unit
// Assumes: Word-indexed register port, 16-bit data
// Notes:   Definitions only
`ifndef TCCU_MAP_VH
`define TCCU_MAP_VH

`define ADDR_W            4
`define DATA_W            16

`define OFF_TPC           4'h0
`define OFF_TMR1          4'h1
`define OFF_TMR2          4'h2
`define OFF_PER1          4'h3
`define OFF_PER2          4'h4
`define OFF_CAP_CTRL      4'h5
`define OFF_CAP_DATA      4'h6
`define OFF_CAP_STAT      4'h7
`define OFF_CMP_CTRL      4'h8
`define OFF_CMP_PRI       4'h9
`define OFF_CMP_SEC       4'ha
`define OFF_EVT_STAT      4'hb

`define TPC_RUN           15
`define TPC_IDLE_STOP     13
`define TPC_GATE          6
`define TPC_PS_HI         5
`define TPC_PS_LO         4
`define TPC_CHAIN         3
`define TPC_CLKSRC        1
`define TPC_MASK          16'ha07a
`define TPC_RESET         16'h0000
`define PER_RESET         16'hffff

`define CAP_MODE_HI       2
`define CAP_MODE_LO       0
`define CAP_TSEL          7
`define CAP_THR_HI        6
`define CAP_THR_LO        5

`define CAPM_OFF          3'h0
`define CAPM_EDGE         3'h1
`define CAPM_FALL         3'h2
`define CAPM_RISE         3'h3
`define CAPM_RISE4        3'h4
`define CAPM_RISE16       3'h5

`define CMP_MODE_HI       2
`define CMP_MODE_LO       0
`define CMP_TSEL          3

`define CMPM_OFF          3'h0
`define CMPM_OS_HIGH      3'h1
`define CMPM_OS_LOW       3'h2
`define CMPM_TOGGLE       3'h3
`define CMPM_DELAYED      3'h4
`define CMPM_CONT         3'h5
`define CMPM_PWM          3'h6
`define CMPM_PWM_FAULT    3'h7

`define EVT_CAP           0
`define EVT_CMP           1
`define EVT_FAULT         2
`define EVT_OVF           3

`endif

//--- tccu_properties.sv
// Purpose: Port-level checks of the timer/capture/compare unit
// Assumes: Bound to the unit's top module
// Notes:   Shadows of control and compare mode follow software writes
`timescale 1ns/10ps
`include "tccu_map.vh"
module tccu_properties (
  input logic        CLK,
  input logic        RESET,
  input logic [3:0]  ADDR,
  input logic [15:0] WDATA,
  input logic        WR,
  input logic        RD,
  input logic [15:0] RDATA,
  input logic        CAPTURE_PIN,
  input logic        FAULT_PIN,
  input logic        IDLE_MODE,
  input logic        SLEEP_MODE,
  input logic        COMPARE_PIN,
  input logic        CAPTURE_IRQ,
  input logic        COMPARE_IRQ,
  input logic        WAKE_REQ
);
  logic [15:0] tpc_q;
  logic [2:0]  cmode_q;
  logic [7:0]  hist_q;
  logic [1:0]  off_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tpc_q   <= `TPC_RESET;
      cmode_q <= `CMPM_OFF;
      hist_q  <= 8'h00;
      off_q   <= 2'h0;
    end else begin
      if (WR && ADDR == `OFF_TPC)
        tpc_q <= WDATA & `TPC_MASK;
      if (WR && ADDR == `OFF_CMP_CTRL)
        cmode_q <= WDATA[2:0];
      hist_q <= {hist_q[6:0], CAPTURE_PIN};
      off_q  <= (cmode_q != `CMPM_OFF || (WR && ADDR == `OFF_CMP_CTRL)) ? 2'h0
              : off_q + {1'b0, off_q != 2'h3};
    end
  end
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_rdata_unmapped: assert property ($past(RD && ADDR > `OFF_EVT_STAT) |-> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property ($past(RD && ADDR == `OFF_TPC) |-> RDATA == tpc_q)
    else $error("timer pair control read mismatch");
  a_wake_lowpower: assert property (WAKE_REQ |-> SLEEP_MODE || IDLE_MODE)
    else $error("wake request outside sleep or idle");
  a_wake_cause: assert property (WAKE_REQ |-> hist_q != 8'h00 && hist_q != 8'hff)
    else $error("wake request without capture pin edge");
  a_capirq_hold: assert property (CAPTURE_IRQ &&
    !(WR && ADDR == `OFF_EVT_STAT && WDATA[0]) |=> CAPTURE_IRQ)
    else $error("capture interrupt dropped without clear");
  a_capirq_cause: assert property ($rose(CAPTURE_IRQ) |->
    hist_q != 8'h00 && hist_q != 8'hff)
    else $error("capture interrupt without capture pin edge");
  a_cmpirq_hold: assert property (COMPARE_IRQ &&
    !(WR && ADDR == `OFF_EVT_STAT && WDATA[1]) |=> COMPARE_IRQ)
    else $error("compare interrupt dropped without clear");
  a_fault_force: assert property (
    (cmode_q == `CMPM_PWM_FAULT && FAULT_PIN && !WR)[*4] |=> !COMPARE_PIN)
    else $error("compare output active during fault");
  a_off_steady: assert property (off_q == 2'h3 |-> $stable(COMPARE_PIN))
    else $error("compare output moved with compare off");
endmodule

//--- tccu_pin_model.sv
// Purpose: Signal sources on the capture, clock, gate and fault pins
// Assumes: Called from the bench just after a rising clock edge
// Notes:   Levels held 4 cycles so the three-stage sync sees each edge
`timescale 1ns/10ps
module tccu_pin_model (
  input  logic CLK,
  output logic ext_clk,
  output logic cap,
  output logic fault,
  output logic gate
);
  initial begin
    ext_clk = 1'b0;
    cap = 1'b0;
    fault = 1'b0;
    gate = 1'b0;
  end
  task automatic pulses(input bit on_ext, input int n);
    repeat (n) begin
      @(posedge CLK);
      if (on_ext) ext_clk <= 1'b1; else cap <= 1'b1;
      repeat (4) @(posedge CLK);
      if (on_ext) ext_clk <= 1'b0; else cap <= 1'b0;
      repeat (4) @(posedge CLK);
    end
  endtask
  task automatic levels(input bit f);
    @(posedge CLK);
    fault <= f;
  endtask
  task automatic gate_level(input bit g);
    @(posedge CLK);
    gate <= g;
  endtask
endmodule

//--- timer_capture_compare_unit_bench.sv
// Purpose: Self-checking bench for the timer/capture/compare unit
// Assumes: Timer values are read with the timer stopped
// Notes:   Pins come from the pin model
`timescale 1ns/10ps
`include "tccu_map.vh"
bind timer_capture_compare_unit tccu_properties u_props (
  .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CAPTURE_PIN(CAPTURE_PIN), .FAULT_PIN(FAULT_PIN),
  .IDLE_MODE(IDLE_MODE), .SLEEP_MODE(SLEEP_MODE), .COMPARE_PIN(COMPARE_PIN),
  .CAPTURE_IRQ(CAPTURE_IRQ), .COMPARE_IRQ(COMPARE_IRQ), .WAKE_REQ(WAKE_REQ));
module timer_capture_compare_unit_bench;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        IDLE_MODE = 1'b0;
  logic        SLEEP_MODE = 1'b0;
  logic [15:0] RDATA;
  logic        EXT_CLK_PIN, GATE_PIN, CAPTURE_PIN, FAULT_PIN;
  logic        COMPARE_PIN, CAPTURE_IRQ, COMPARE_IRQ, WAKE_REQ, p0, hi;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          wakes = 0;
  int          np [1:5] = '{2, 3, 1, 8, 16};
  int          fill [1:5] = '{4, 3, 1, 2, 1};
  int          div [0:3] = '{1, 8, 64, 256};
  always #2.5 CLK = ~CLK;
  always @(posedge CLK)
    if (WAKE_REQ === 1'b1) wakes <= wakes + 1;
  tccu_pin_model u_pins (.CLK(CLK), .ext_clk(EXT_CLK_PIN), .cap(CAPTURE_PIN),
    .fault(FAULT_PIN), .gate(GATE_PIN));
  timer_capture_compare_unit u_dut (
    .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EXT_CLK_PIN(EXT_CLK_PIN), .GATE_PIN(GATE_PIN),
    .CAPTURE_PIN(CAPTURE_PIN), .FAULT_PIN(FAULT_PIN), .IDLE_MODE(IDLE_MODE),
    .SLEEP_MODE(SLEEP_MODE), .COMPARE_PIN(COMPARE_PIN), .CAPTURE_IRQ(CAPTURE_IRQ),
    .COMPARE_IRQ(COMPARE_IRQ), .WAKE_REQ(WAKE_REQ));
  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    chk($sformatf("register %h", a), exp, RDATA);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    rd(`OFF_TPC, `TPC_RESET);
    rd(`OFF_PER1, `PER_RESET);
    rd(4'hc, 16'h0000);
    wr(`OFF_TPC, 16'hffff);
    rd(`OFF_TPC, `TPC_MASK);
    wr(`OFF_TMR1, 16'h0000);
    wr(`OFF_TPC, 16'h8000);
    repeat (10) @(posedge CLK);
    wr(`OFF_TPC, 16'h0000);
    rd(`OFF_TMR1, 16'h000c);
    rd(`OFF_TMR2, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_TMR1, 16'h0000);
      wr(`OFF_TPC, 16'h8000 | 16'(i << 4));
      repeat (3 * div[i] - 2) @(posedge CLK);
      wr(`OFF_TPC, 16'h0000);
      rd(`OFF_TMR1, 16'h0003);
    end
    wr(`OFF_TMR1, 16'hfffe);
    wr(`OFF_TPC, 16'h8008);
    @(posedge CLK);
    wr(`OFF_TPC, 16'h0000);
    rd(`OFF_TMR1, 16'h0001);
    rd(`OFF_TMR2, 16'h0001);
    wr(`OFF_TMR1, 16'h0000);
    wr(`OFF_TPC, 16'h8042);
    u_pins.pulses(1'b1, 5);
    wr(`OFF_TPC, 16'h0000);
    rd(`OFF_TMR1, 16'h0005);
    wr(`OFF_TPC, 16'h8040);
    repeat (20) @(posedge CLK);
    rd(`OFF_TMR1, 16'h0005);
    u_pins.gate_level(1'b1);
    repeat (10) @(posedge CLK);
    u_pins.gate_level(1'b0);
    repeat (4) @(posedge CLK);
    rd(`OFF_TMR1, 16'h0010);
    wr(`OFF_TMR1, 16'h0005);
    @(posedge CLK);
    IDLE_MODE <= 1'b1;
    wr(`OFF_TPC, 16'ha000);
    repeat (20) @(posedge CLK);
    rd(`OFF_TMR1, 16'h0005);
    wr(`OFF_TPC, 16'h8000);
    wr(`OFF_TPC, 16'h0000);
    rd(`OFF_TMR1, 16'h0007);
    @(posedge CLK);
    IDLE_MODE <= 1'b0;
    SLEEP_MODE <= 1'b1;
    for (int m = 1; m < 6; m++) begin
      wr(`OFF_TMR1, 16'(m));
      wr(`OFF_CAP_CTRL, 16'(m));
      u_pins.pulses(1'b0, np[m]);
      wr(`OFF_CAP_CTRL, 16'h0000);
      rd(`OFF_CAP_STAT, 16'(fill[m]));
      repeat (fill[m]) rd(`OFF_CAP_DATA, 16'(m));
    end
    rd(`OFF_CAP_DATA, 16'h0000);
    chk("wake seen", 16'h0001, 16'(wakes != 0));
    wr(`OFF_EVT_STAT, 16'h000f);
    wr(`OFF_CAP_CTRL, 16'h00a3);
    wr(`OFF_TMR2, 16'h0aa0);
    u_pins.pulses(1'b0, 1);
    @(negedge CLK) chk("capture irq", 16'h0000, CAPTURE_IRQ);
    wr(`OFF_TMR2, 16'h0bb0);
    u_pins.pulses(1'b0, 1);
    @(negedge CLK) chk("capture irq", 16'h0001, CAPTURE_IRQ);
    rd(`OFF_CAP_DATA, 16'h0aa0);
    rd(`OFF_CAP_DATA, 16'h0bb0);
    wr(`OFF_EVT_STAT, 16'h0001);
    @(negedge CLK) chk("capture irq", 16'h0000, CAPTURE_IRQ);
    for (int m = 0; m < 8; m++) begin
      wr(`OFF_CMP_CTRL, 16'(m));
      rd(`OFF_CMP_CTRL, 16'(m));
    end
    wr(`OFF_CMP_CTRL, 16'(`CMPM_OFF));
    wr(`OFF_EVT_STAT, 16'h000f);
    wr(`OFF_TMR1, 16'h0000);
    wr(`OFF_CMP_PRI, 16'h0008);
    wr(`OFF_CMP_CTRL, 16'(`CMPM_TOGGLE));
    @(negedge CLK) p0 = COMPARE_PIN;
    wr(`OFF_TPC, 16'h8000);
    repeat (20) @(posedge CLK);
    wr(`OFF_TPC, 16'h0000);
    @(negedge CLK) chk("compare pin", 16'(!p0), COMPARE_PIN);
    chk("compare irq", 16'h0001, COMPARE_IRQ);
    wr(`OFF_TMR1, 16'h0000);
    wr(`OFF_CMP_PRI, 16'h0004);
    wr(`OFF_CMP_SEC, 16'h000c);
    wr(`OFF_CMP_CTRL, 16'(`CMPM_CONT));
    for (int k = 0; k < 2; k++) begin
      wr(`OFF_TPC, 16'h8000);
      repeat (6) @(posedge CLK);
      wr(`OFF_TPC, 16'h0000);
      @(negedge CLK) chk("pulse level", 16'(k == 0), COMPARE_PIN);
    end
    wr(`OFF_TMR1, 16'h0000);
    wr(`OFF_PER1, 16'h0010);
    wr(`OFF_CMP_CTRL, 16'(`CMPM_PWM_FAULT));
    wr(`OFF_TPC, 16'h8000);
    u_pins.levels(1'b1);
    repeat (8) @(posedge CLK);
    u_pins.levels(1'b0);
    repeat (40) @(posedge CLK);
    @(negedge CLK) chk("pin locked", 16'h0000, COMPARE_PIN);
    hi = 1'b0;
    wr(`OFF_CMP_CTRL, 16'(`CMPM_PWM_FAULT));
    repeat (40) @(negedge CLK) hi = hi | COMPARE_PIN;
    chk("pwm resumes", 16'h0001, hi);
    wr(`OFF_TPC, 16'h0000);
    end_of_test();
  end
endmodule
